// File: verilog/fepoc_pkg.sv
`default_nettype none
package fepoc_pkg;
  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_REG_READ   = 8'h65;
  localparam logic [7:0] OP_REG_WRITE  = 8'h71;
  localparam logic [7:0] OP_BURST_LEN  = 8'hC0;
  localparam logic [7:0] OP_CLR_RESUME = 8'h30;
  localparam logic [7:0] OP_RST_ENABLE = 8'h66;
  localparam logic [7:0] OP_RST_DO     = 8'h99;
  localparam logic [7:0] OP_RST_LEGACY = 8'hF0;
  localparam logic [7:0] OP_PARAM_ER   = 8'h20;
  localparam logic [7:0] OP_PARAM_ER4  = 8'h21;
  localparam logic [7:0] OP_BLOCK_ER   = 8'hD8;
  localparam logic [7:0] OP_BLOCK_ER4  = 8'hDC;
  localparam logic [7:0] OP_BULK_ER    = 8'h60;
  localparam logic [7:0] OP_BULK_ER2   = 8'hC7;
  // ****************************************
  // register addresses
  // ****************************************
  localparam logic [23:0] ADDR_OPTIONS = 24'h000004;
  localparam logic [23:0] ADDR_BURST   = 24'h000005;
  // ****************************************
  // option register fields
  // ****************************************
  localparam int BIT_BLANK_CHECK = 5;
  localparam int BIT_PAGE_WRAP   = 4;
  localparam int BIT_PARAM_DIS   = 3;
  localparam int BIT_RESUME_SEL  = 2;
  localparam int BIT_BLOCK_SIZE  = 1;
  localparam int BIT_LEGACY_RST  = 0;
  localparam logic [7:0] OPT_WR_MASK = 8'h37;
  localparam logic [7:0] OPT_RD_MASK = 8'h3F;
  localparam int BIT_WRAP_DIS    = 4;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // ****************************************
  // page buffer
  // ****************************************
  localparam int BUF_AW          = 9;
  localparam int BUF_SMALL_AW    = 8;
  // ****************************************
  // erase kinds
  // ****************************************
  typedef enum logic [1:0] {EK_4K, EK_64K, EK_256K, EK_BULK} fepoc_kind_e;
endpackage : fepoc_pkg
`default_nettype wire

// File: verilog/fepoc_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface fepoc_ctl_if;
  import fepoc_pkg::*;
  logic        rd_reg;
  logic        wr_reg;
  logic        set_burst_length_cmd;
  logic        clr_status;
  logic        resume;
  logic        soft_reset;
  logic        erase_go;
  fepoc_kind_e erase_kind;
  logic [23:0] addr;
  logic [7:0]  wdata;
  logic        erase_start;
  logic        erase_skip;
  logic        scan_start;
  logic        seq_busy;
  modport dec (output rd_reg, wr_reg, set_burst_length_cmd, clr_status, resume, soft_reset,
               erase_go, erase_kind, addr, wdata);
  modport seq (input erase_go, soft_reset,
               output erase_start, erase_skip, scan_start, seq_busy);
  modport top (input rd_reg, wr_reg, set_burst_length_cmd, clr_status, resume, soft_reset,
               erase_go, erase_kind, addr, wdata, erase_start, erase_skip,
               scan_start, seq_busy);
endinterface : fepoc_ctl_if
`default_nettype wire

// File: verilog/fepoc_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module fepoc_cmd_decode
  import fepoc_pkg::*;
(
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // command in
  input  wire logic       req_valid,
  input  wire logic [7:0] req_opcode,
  input  wire logic [23:0] req_addr,
  input  wire logic [7:0] req_wdata,
  // option bits
  input  wire logic       resume_opcode_select,
  input  wire logic       legacy_reset_enable,
  input  wire logic       block_erase_size_select,
  // decoded
  fepoc_ctl_if.dec        ctl
);
  typedef struct packed {
    logic        armed;
    logic        rd_reg;
    logic        wr_reg;
    logic        set_burst_length_cmd;
    logic        clr_status;
    logic        resume;
    logic        soft_reset;
    logic        erase_go;
    fepoc_kind_e kind;
    logic [23:0] addr;
    logic [7:0]  wdata;
  } fepoc_dec_s;

  fepoc_dec_s st_r;
  fepoc_dec_s st_nxt;

  // ****************************************
  // opcode decode
  // ****************************************
  always_comb
  begin
    st_nxt            = st_r;
    st_nxt.rd_reg     = 1'b0;
    st_nxt.wr_reg     = 1'b0;
    st_nxt.set_burst_length_cmd        = 1'b0;
    st_nxt.clr_status = 1'b0;
    st_nxt.resume     = 1'b0;
    st_nxt.soft_reset = 1'b0;
    st_nxt.erase_go   = 1'b0;
    if (req_valid)
    begin
      st_nxt.armed = 1'b0;
      st_nxt.addr  = req_addr;
      st_nxt.wdata = req_wdata;
      case (req_opcode)
        OP_REG_READ:   st_nxt.rd_reg = 1'b1;
        OP_REG_WRITE:  st_nxt.wr_reg = 1'b1;
        OP_BURST_LEN:  st_nxt.set_burst_length_cmd = 1'b1;
        OP_CLR_RESUME:
        begin
          st_nxt.resume     = resume_opcode_select;
          st_nxt.clr_status = !resume_opcode_select;
        end
        OP_RST_ENABLE: st_nxt.armed = 1'b1;
        OP_RST_DO:     st_nxt.soft_reset = st_r.armed;
        OP_RST_LEGACY: st_nxt.soft_reset = legacy_reset_enable;
        OP_PARAM_ER, OP_PARAM_ER4:
        begin
          st_nxt.erase_go = 1'b1;
          st_nxt.kind     = EK_4K;
        end
        OP_BLOCK_ER, OP_BLOCK_ER4:
        begin
          st_nxt.erase_go = 1'b1;
          st_nxt.kind = block_erase_size_select ? EK_256K : EK_64K;
        end
        OP_BULK_ER, OP_BULK_ER2:
        begin
          st_nxt.erase_go = 1'b1;
          st_nxt.kind     = EK_BULK;
        end
        default: st_nxt.armed = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign ctl.rd_reg     = st_r.rd_reg;
  assign ctl.wr_reg     = st_r.wr_reg;
  assign ctl.set_burst_length_cmd        = st_r.set_burst_length_cmd;
  assign ctl.clr_status = st_r.clr_status;
  assign ctl.resume     = st_r.resume;
  assign ctl.soft_reset = st_r.soft_reset;
  assign ctl.erase_go   = st_r.erase_go;
  assign ctl.erase_kind = st_r.kind;
  assign ctl.addr       = st_r.addr;
  assign ctl.wdata      = st_r.wdata;
endmodule : fepoc_cmd_decode
`default_nettype wire

// File: verilog/fepoc_erase_seq.sv
`timescale 1ns/1ps
`default_nettype none
module fepoc_erase_seq
  import fepoc_pkg::*;
(
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rstn,
  // option and array status
  input  wire logic blank_check_enable,
  input  wire logic prev_erase_ok,
  input  wire logic scan_zero_found,
  input  wire logic scan_done,
  // control
  fepoc_ctl_if.seq  ctl
);
  typedef enum logic {SQ_IDLE, SQ_SCAN} fepoc_seq_e;
  typedef struct packed {
    fepoc_seq_e state;
    logic       start;
    logic       skip;
    logic       scan;
  } fepoc_seq_s;

  fepoc_seq_s st_r;
  fepoc_seq_s st_nxt;

  // ****************************************
  // blank check sequence
  // ****************************************
  always_comb
  begin
    st_nxt       = st_r;
    st_nxt.start = 1'b0;
    st_nxt.skip  = 1'b0;
    st_nxt.scan  = 1'b0;
    case (st_r.state)
      SQ_IDLE:
        if (ctl.erase_go)
        begin
          if (!blank_check_enable)
            st_nxt.start = 1'b1;
          else if (!prev_erase_ok)
            st_nxt.start = 1'b1;
          else
          begin
            st_nxt.scan  = 1'b1;
            st_nxt.state = SQ_SCAN;
          end
        end
      SQ_SCAN:
        if (scan_zero_found)
        begin
          st_nxt.start = 1'b1;
          st_nxt.state = SQ_IDLE;
        end
        else if (scan_done)
        begin
          st_nxt.skip  = 1'b1;
          st_nxt.state = SQ_IDLE;
        end
      default: st_nxt.state = SQ_IDLE;
    endcase
    if (ctl.soft_reset)
      st_nxt = '0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign ctl.erase_start = st_r.start;
  assign ctl.erase_skip  = st_r.skip;
  assign ctl.scan_start  = st_r.scan;
  assign ctl.seq_busy    = (st_r.state == SQ_SCAN);
endmodule : fepoc_erase_seq
`default_nettype wire

// File: verilog/fepoc_top.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - option register via generic read/write
// - resets reload options from nonvolatile copy
// - failed prior erase means erase directly
// - good prior erase: scan, erase on zero
// - blank check for all erases; off: erase
// - page wrap bit chooses 256 or 512
// - parameter sector bit maps or removes sectors
// - parameter bit read-only, follows nonvolatile
// - 30h resume or clear status by bit
// - D8h/DCh erase 256K or 64K by bit
// - F0h reset only when legacy bit set
// - 66h then 99h as the next command resets; any other command between them cancels it
// - burst wrap only for main array reads
// - resets reload burst wrap from nonvolatile
// - burst wrap writable by write or C0h
module fepoc_top
  import fepoc_pkg::*;
#(
  parameter logic [23:0] OPT_ADDR   = ADDR_OPTIONS,
  parameter logic [23:0] BURST_ADDR = ADDR_BURST
)
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rstn,
  input  wire logic                hw_reset,
  // command port
  input  wire logic                req_valid,
  input  wire logic [7:0]          req_opcode,
  input  wire logic [23:0]         req_addr,
  input  wire logic [7:0]          req_wdata,
  output logic                     rd_valid,
  output logic [7:0]               rd_data,
  // nonvolatile copies
  input  wire logic [7:0]          opts_nv,
  input  wire logic [7:0]          burst_nv,
  // erase status
  input  wire logic                prev_erase_ok,
  input  wire logic                scan_zero_found,
  input  wire logic                scan_done,
  output logic                     erase_start,
  output logic                     erase_skip,
  output logic                     scan_start,
  output logic                     erase_busy,
  output logic [1:0]               erase_size,
  // page buffer
  input  wire logic [BUF_AW-1:0]   buf_load_addr,
  output logic [BUF_AW-1:0]        buf_wr_addr,
  // read path
  input  wire logic                read_is_array,
  output logic                     burst_wrap_active,
  output logic [1:0]               burst_wrap_len,
  // command actions
  output logic                     clear_status,
  output logic                     resume_pulse,
  output logic                     soft_reset,
  // option outputs
  output logic                     blank_check_enable,
  output logic                     page_buffer_wrap_select,
  output logic                     param_sectors_mapped,
  output logic                     resume_opcode_select,
  output logic                     block_erase_size_select,
  output logic                     legacy_reset_enable,
  output logic [7:0]               burst_wrap_config_volatile
);
  if (OPT_ADDR == BURST_ADDR)
  begin : g_addr_check
    $error("option and burst addresses must differ");
  end

  typedef struct packed {
    logic [7:0]          opts;
    logic [7:0]          burst;
    logic                rd_valid;
    logic [7:0]          rd_data;
    logic [1:0]          esize;
    logic [BUF_AW-1:0]   buf_addr;
    logic                wrap_act;
    logic                clr;
    logic                res;
    logic                srst;
    logic                start;
    logic                skip;
    logic                scan;
    logic                busy;
  } fepoc_top_s;

  fepoc_top_s st_r;
  fepoc_top_s st_nxt;
  logic       reload;

  fepoc_ctl_if ctl ();

  // ****************************************
  // submodules
  // ****************************************
  fepoc_cmd_decode u_dec (
    .clk_sys                 (clk_sys),
    .rstn                    (rstn),
    .req_valid               (req_valid),
    .req_opcode              (req_opcode),
    .req_addr                (req_addr),
    .req_wdata               (req_wdata),
    .resume_opcode_select    (st_r.opts[BIT_RESUME_SEL]),
    .legacy_reset_enable     (st_r.opts[BIT_LEGACY_RST]),
    .block_erase_size_select (st_r.opts[BIT_BLOCK_SIZE]),
    .ctl                     (ctl.dec)
  );

  fepoc_erase_seq u_seq (
    .clk_sys            (clk_sys),
    .rstn               (rstn),
    .blank_check_enable (st_r.opts[BIT_BLANK_CHECK]),
    .prev_erase_ok      (prev_erase_ok),
    .scan_zero_found    (scan_zero_found),
    .scan_done          (scan_done),
    .ctl                (ctl.seq)
  );

  // ****************************************
  // register file and outputs
  // ****************************************
  assign reload = hw_reset || ctl.soft_reset;

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.rd_valid = 1'b0;
    st_nxt.clr      = ctl.clr_status;
    st_nxt.res      = ctl.resume;
    st_nxt.srst     = ctl.soft_reset;
    st_nxt.start    = ctl.erase_start;
    st_nxt.skip     = ctl.erase_skip;
    st_nxt.scan     = ctl.scan_start;
    st_nxt.busy     = ctl.seq_busy;
    if (ctl.erase_go)
      st_nxt.esize = ctl.erase_kind;
    if (ctl.rd_reg)
    begin
      st_nxt.rd_valid = 1'b1;
      if (ctl.addr == OPT_ADDR)
        st_nxt.rd_data = st_r.opts & OPT_RD_MASK;
      else if (ctl.addr == BURST_ADDR)
        st_nxt.rd_data = st_r.burst;
      else
        st_nxt.rd_data = RD_UNMAPPED;
    end
    if (ctl.wr_reg)
    begin
      if (ctl.addr == OPT_ADDR)
        st_nxt.opts = ctl.wdata & OPT_WR_MASK;
      else if (ctl.addr == BURST_ADDR)
        st_nxt.burst = ctl.wdata;
    end
    if (ctl.set_burst_length_cmd)
      st_nxt.burst = ctl.wdata;
    // parameter-sector bit tracks the nonvolatile bit only
    st_nxt.opts[BIT_PARAM_DIS] = opts_nv[BIT_PARAM_DIS];
    if (st_r.opts[BIT_PAGE_WRAP])
      st_nxt.buf_addr = buf_load_addr;
    else
      st_nxt.buf_addr = {1'b0, buf_load_addr[BUF_SMALL_AW-1:0]};
    st_nxt.wrap_act = read_is_array && !st_r.burst[BIT_WRAP_DIS];
    if (reload)
    begin
      st_nxt.opts  = opts_nv & OPT_RD_MASK;
      st_nxt.burst = burst_nv;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      st_r       <= '0;
      st_r.opts  <= opts_nv & OPT_RD_MASK;
      st_r.burst <= burst_nv;
    end
    else
      st_r <= st_nxt;
  end

  assign rd_valid                   = st_r.rd_valid;
  assign rd_data                    = st_r.rd_data;
  assign erase_start                = st_r.start;
  assign erase_skip                 = st_r.skip;
  assign scan_start                 = st_r.scan;
  assign erase_busy                 = st_r.busy;
  assign erase_size                 = st_r.esize;
  assign buf_wr_addr                = st_r.buf_addr;
  assign burst_wrap_active          = st_r.wrap_act;
  assign burst_wrap_len             = st_r.burst[1:0];
  assign clear_status               = st_r.clr;
  assign resume_pulse               = st_r.res;
  assign soft_reset                 = st_r.srst;
  assign blank_check_enable         = st_r.opts[BIT_BLANK_CHECK];
  assign page_buffer_wrap_select    = st_r.opts[BIT_PAGE_WRAP];
  assign param_sectors_mapped       = !st_r.opts[BIT_PARAM_DIS];
  assign resume_opcode_select       = st_r.opts[BIT_RESUME_SEL];
  assign block_erase_size_select    = st_r.opts[BIT_BLOCK_SIZE];
  assign legacy_reset_enable        = st_r.opts[BIT_LEGACY_RST];
  assign burst_wrap_config_volatile = st_r.burst;
endmodule : fepoc_top
`default_nettype wire

// File: tb/fepoc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fepoc_asserts
  import fepoc_pkg::*;
(
  // clock and reset
  input wire logic              clk_sys,
  input wire logic              rstn,
  // command port
  input wire logic              req_valid,
  input wire logic [7:0]        req_opcode,
  input wire logic [23:0]       req_addr,
  input wire logic              rd_valid,
  input wire logic [7:0]        rd_data,
  // options
  input wire logic [7:0]        opts_nv,
  input wire logic              param_sectors_mapped,
  input wire logic              legacy_reset_enable,
  input wire logic              soft_reset,
  input wire logic              page_buffer_wrap_select,
  input wire logic [BUF_AW-1:0] buf_load_addr,
  input wire logic [BUF_AW-1:0] buf_wr_addr,
  // erase
  input wire logic              blank_check_enable,
  input wire logic              prev_erase_ok,
  input wire logic              erase_busy,
  input wire logic              scan_zero_found,
  input wire logic              erase_start
);
  // ****************************************
  // helpers
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic              op_rd, op_er, op_f0, op_66, op_99, rd_opt;
  logic [BUF_AW-1:0] wrap_exp;
  assign op_rd = req_valid && req_opcode == OP_REG_READ;
  assign rd_opt = op_rd && req_addr == ADDR_OPTIONS;
  assign op_f0 = req_valid && req_opcode == OP_RST_LEGACY;
  assign op_66 = req_valid && req_opcode == OP_RST_ENABLE;
  assign op_99 = req_valid && req_opcode == OP_RST_DO;
  assign op_er = req_valid && req_opcode inside {OP_PARAM_ER, OP_PARAM_ER4,
    OP_BLOCK_ER, OP_BLOCK_ER4, OP_BULK_ER, OP_BULK_ER2};
  assign wrap_exp = page_buffer_wrap_select ? buf_load_addr
                                            : {1'b0, buf_load_addr[7:0]};
  sequence s_rst_pair;
    op_66 ##1 op_99;
  endsequence
  sequence s_direct_erase;
    op_er && !erase_busy && !(blank_check_enable && prev_erase_ok);
  endsequence
  // ****************************************
  // properties
  // ****************************************
  chk_read_answer: assert property (op_rd |-> ##[2:3] rd_valid)
    else $error("read answer missing");
  chk_reserved_zero: assert property (rd_opt |-> ##2
    (rd_valid && rd_data[7:6] == 2'h0))
    else $error("reserved bits read nonzero");
  chk_param_follows: assert property ($stable(opts_nv) |->
    param_sectors_mapped == !opts_nv[3])
    else $error("parameter bit differs from copy");
  chk_legacy_ignored: assert property (op_f0 && !legacy_reset_enable
    |-> ##1 !soft_reset [*3])
    else $error("legacy reset not ignored");
  chk_pair_resets: assert property (s_rst_pair |->
    ##[1:3] soft_reset)
    else $error("reset pair ignored");
  chk_page_wrap: assert property ($past(rstn) |->
    buf_wr_addr == $past(wrap_exp))
    else $error("buffer address wrap wrong");
  chk_direct_erase: assert property (s_direct_erase |->
    ##[2:3] erase_start)
    else $error("direct erase not started");
  chk_zero_erase: assert property (erase_busy && scan_zero_found |->
    ##[1:2] erase_start)
    else $error("erase after zero not started");
endmodule : fepoc_asserts
bind fepoc_top fepoc_asserts u_chk (.clk_sys, .rstn, .req_valid, .req_opcode,
  .req_addr,
  .rd_valid, .rd_data, .opts_nv, .param_sectors_mapped, .legacy_reset_enable,
  .soft_reset, .page_buffer_wrap_select, .buf_load_addr, .buf_wr_addr,
  .blank_check_enable, .prev_erase_ok, .erase_busy, .scan_zero_found,
  .erase_start);
`default_nettype wire

// File: tb/fepoc_array_model.sv
`timescale 1ns/1ps
`default_nettype none
module fepoc_array_model
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rstn,
  // scan control
  input wire logic       scan_start,
  input wire logic       has_zero,
  input wire logic [3:0] scan_len,
  output logic           scan_zero_found,
  output logic           scan_done
);
  // ****************************************
  // blank scan of the sector
  // ****************************************
  logic [3:0] cnt_r;
  logic       run_r;
  always_ff @(posedge clk_sys)
  begin
    scan_zero_found <= 1'b0;
    scan_done       <= 1'b0;
    if (!rstn)
      run_r <= 1'b0;
    else if (scan_start)
    begin
      run_r <= 1'b1;
      cnt_r <= scan_len;
    end
    else if (run_r)
    begin
      cnt_r <= cnt_r - 4'h1;
      if (cnt_r == 4'h0)
      begin
        run_r           <= 1'b0;
        scan_done       <= 1'b1;
        scan_zero_found <= has_zero;
      end
    end
  end
endmodule : fepoc_array_model
`default_nettype wire

// File: tb/fepoc_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fepoc_tb_top import fepoc_pkg::*;;
  // ****************************************
  // signals
  // ****************************************
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  logic              hw_reset = 1'b0;
  logic              req_valid = 1'b0;
  logic [7:0]        req_opcode = 8'h00;
  logic [23:0]       req_addr = 24'h000000;
  logic [7:0]        req_wdata = 8'h00;
  logic [7:0]        opts_nv = 8'h00;
  logic [7:0]        burst_nv = 8'h00;
  logic              prev_erase_ok = 1'b0;
  logic              has_zero = 1'b0;
  logic [3:0]        scan_len = 4'h0;
  logic [BUF_AW-1:0] buf_load_addr = '0;
  logic              read_is_array = 1'b0;
  logic              scan_zero_found, scan_done, rd_valid, erase_start;
  logic              erase_skip, scan_start, erase_busy, burst_wrap_active;
  logic              clear_status, resume_pulse, soft_reset;
  logic              blank_check_enable, page_buffer_wrap_select;
  logic              param_sectors_mapped, resume_opcode_select;
  logic              block_erase_size_select, legacy_reset_enable;
  logic [1:0]        erase_size, burst_wrap_len;
  logic [7:0]        rd_data, burst_wrap_config_volatile, v;
  logic [BUF_AW-1:0] buf_wr_addr;
  logic [31:0]       rnd = 32'h4D94;
  logic [7:0]        er_ops [6] = '{OP_PARAM_ER, OP_PARAM_ER4, OP_BLOCK_ER,
                                    OP_BLOCK_ER4, OP_BULK_ER, OP_BULK_ER2};
  int                bad_count = 0, tests_run = 0;
  int                n_es, n_sk, n_sr, n_rp, n_cs;
  fepoc_top uut (.*);
  fepoc_array_model u_arr (.*);
  always #12.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    n_es += erase_start;
    n_sk += erase_skip;
    n_sr += soft_reset;
    n_rp += resume_pulse;
    n_cs += clear_status;
  end
  // ****************************************
  // tasks
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr
  function automatic logic [7:0] fn_opt(input logic [7:0] w);
    return (w & 8'h37) | (opts_nv & 8'h08);
  endfunction : fn_opt
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic cmd(input logic [7:0] op, input logic [23:0] a,
                     input logic [7:0] d, input bit hold = 1'b0);
    req_valid  = 1'b1;
    req_opcode = op;
    req_addr   = a;
    req_wdata  = d;
    @(negedge clk_sys);
    if (hold)
      return;
    req_valid = 1'b0;
    @(negedge clk_sys);
  endtask : cmd
  task automatic wopt(input logic [7:0] w);
    cmd(OP_REG_WRITE, ADDR_OPTIONS, w);
    @(negedge clk_sys);
  endtask : wopt
  task automatic rchk(input logic [23:0] a, input logic [7:0] e);
    cmd(OP_REG_READ, a, 8'h00);
    repeat (3)
      if (rd_valid !== 1'b1)
        @(negedge clk_sys);
    chk(rd_valid, 1'b1);
    chk(rd_data, e);
  endtask : rchk
  task automatic reload_chk;
    rchk(ADDR_OPTIONS, opts_nv & 8'h3F);
    rchk(ADDR_BURST, burst_nv);
  endtask : reload_chk
  task automatic dirty(input bit leg);
    cmd(OP_REG_WRITE, ADDR_BURST, ~burst_nv);
    wopt({7'h1B, leg});
  endtask : dirty
  task automatic run(input logic [7:0] op, input int n);
    {n_es, n_sk, n_sr, n_rp, n_cs} = '0;
    cmd(op, 24'h000000, 8'h00);
    repeat (n) @(negedge clk_sys);
  endtask : run
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    rnd = lfsr(rnd);
    opts_nv = rnd[7:0];
    burst_nv = rnd[15:8];
    repeat (5) @(negedge clk_sys);
    rstn = 1'b1;
    reload_chk;
    rchk(24'h0000FF, 8'h00);
    $display("reset load done");
    for (int i = 0; i < 10; i++)
    begin
      rnd = lfsr(rnd);
      v = (i < 2) ? {8{i[0]}} : rnd[7:0];
      wopt(v);
      rchk(ADDR_OPTIONS, fn_opt(v));
      chk({blank_check_enable, page_buffer_wrap_select, resume_opcode_select,
           block_erase_size_select, legacy_reset_enable},
          {v[5:4], v[2:0]});
      chk(param_sectors_mapped, !opts_nv[3]);
      cmd(rnd[8] ? OP_BURST_LEN : OP_REG_WRITE, ADDR_BURST, rnd[23:16]);
      rchk(ADDR_BURST, rnd[23:16]);
      chk(burst_wrap_config_volatile, rnd[23:16]);
      buf_load_addr = (i < 2) ? {1'b1, {8{i[0]}}} : rnd[31:23];
      read_is_array = rnd[9];
      @(negedge clk_sys);
      chk(buf_wr_addr,
          v[4] ? buf_load_addr : {1'b0, buf_load_addr[7:0]});
      chk(burst_wrap_active, read_is_array & ~rnd[20]);
      chk(burst_wrap_len, rnd[17:16]);
    end
    $display("register access done");
    dirty(1'b0);
    hw_reset = 1'b1;
    @(negedge clk_sys);
    hw_reset = 1'b0;
    reload_chk;
    for (int k = 0; k < 4; k++)
    begin
      dirty(k == 1);
      if (k > 1)
        cmd(OP_RST_ENABLE, 24'h000000, 8'h00, 1'b1);
      if (k > 2)
        cmd(OP_CLR_RESUME, 24'h000000, 8'h00, 1'b1);
      run((k > 1) ? OP_RST_DO : OP_RST_LEGACY, 6);
      chk(n_sr, k == 1 || k == 2);
      if (k == 1 || k == 2)
        reload_chk;
      else
        rchk(ADDR_OPTIONS, fn_opt(8'h36));
    end
    for (int s = 0; s < 2; s++)
    begin
      wopt({5'h00, s[0], 2'h0});
      run(OP_CLR_RESUME, 6);
      chk(n_rp, s);
      chk(n_cs, 1 - s);
    end
    $display("reset and opcode select done");
    for (int i = 0; i < 6; i++)
      for (int k = 0; k < 5; k++)
      begin
        rnd = lfsr(rnd);
        scan_len = rnd[3:0];
        prev_erase_ok = (k != 2);
        has_zero = (k == 3);
        wopt((k < 2) ? {6'h00, k[0], 1'b0} : 8'h20);
        run(er_ops[i], 24);
        chk(n_es, k != 4);
        chk(n_sk, k == 4);
        chk(erase_busy, 1'b0);
        chk(erase_size,
            (i < 2) ? 0 : (i > 3) ? 3 : (k == 1) ? 2 : 1);
      end
    $display("erase done");
    finish_test;
  end
  initial
  begin
    #(25 * 20000);
    bad_count++;
    finish_test;
  end
endmodule : fepoc_tb_top
`default_nettype wire
